// file: inc/nvm_access_pkg.sv
package nvm_access_pkg;

  // ---------------------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_DATA_LOW  = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
  localparam logic [7:0] OFS_CONTROL   = 8'h10;
  localparam logic [7:0] OFS_UNLOCK    = 8'h14;
  localparam logic [7:0] OFS_FLAGS     = 8'h18;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTL_SPACE  = 7;
  localparam int CTL_ABORT  = 3;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_WRITE  = 1;
  localparam int CTL_READ   = 0;
  localparam int FLG_DONE   = 7;

  // ---------------------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------------------
  localparam int EE_DEPTH    = 256;
  localparam int EE_ADDR_W   = 8;
  localparam int DATA_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 5;
  localparam int PROG_ADDR_W = 13;
  localparam int PROG_WORD_W = 14;
  localparam int CNT_W       = 16;

  localparam logic [PROG_ADDR_W-1:0] SMALL_FLASH_MASK = 13'h0fff;
  localparam logic [PROG_ADDR_W-1:0] LARGE_FLASH_MASK = 13'h1fff;

  // ---------------------------------------------------------------------------
  // unlock keys and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    UNL_NONE,
    UNL_HALF,
    UNL_ARMED
  } unlock_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PG_ADDR,
    ST_PG_CAPTURE,
    ST_WRITING
  } state_e;

endpackage : nvm_access_pkg

// file: verilog/nvm_indirect_access_ctrl.sv
// Functional notes
// (RL1) data store is 256 bytes, addressed by address-low, value in data-low
// (RL2) program reads return a 14-bit word from a 13-bit two-register address
// (RL3) program flash is 4K or 8K words by variant; address masked accordingly
// (RL4) program space is read-only; no write or erase path exists
// (RL5) byte write erases and programs the location in one cycle
// (RL6) write length is set by an internal timer, not by software
// (RL7) code protection removes programmer access but keeps processor access
// (RL8) software loads both address registers for program, low only for data
// (RL9) space select at control bit 7 picks data or program, reset clear
// (RL10) read-start and write-start set by software, cleared only by hardware
// (RL11) write-permit gates byte writes and is clear after reset
// (RL12) reset sources cutting a write set the abort flag
// (RL13) such reset clears data and address registers, abort flag kept
// (RL14) write completion sets flag bit 7; software clears it
// (RL15) unlock port stores nothing and reads zero
// (RL16) data-high holds word bits 13..8 in bits 5..0, upper bits zero
// (RL17) address-high holds bits 12..8 in bits 4..0, upper bits zero
// (RL18) control layout: select 7, abort 3, permit 2, write 1, read 0
// (RL19) read-start begins a read of the selected space and self-clears
// (RL20) write starts only after 55h then AAh to unlock, then write-start
// (RL21) write-start needs permit; clearing permit later does not stop it
// (RL22) write-start with program space selected is dropped at once
// (RL23) read data lands next cycle; program read uses the second cycle
// (RL24) write cycle length is a parameter in clock cycles
// (RL25) starts and register loads are ignored while a write is busy; the code still loads permit, abort and the done flag then
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
module nvm_indirect_access_ctrl
  import nvm_access_pkg::*;
#(
  parameter int WRITE_CYCLES = 1000,
  parameter bit LARGE_FLASH  = 1'b1
) (
  // clock and power-on reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // warm reset sources
  input  wire logic                   extResetReq,
  input  wire logic                   watchdogResetReq,
  input  wire logic                   brownoutResetReq,
  // program flash read port
  output logic [PROG_ADDR_W-1:0]      flashAddr,
  input  wire logic [PROG_WORD_W-1:0] flashData,
  // code protection
  input  wire logic                   codeProtect,
  output logic                        programmerAccess
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_CYCLES - 1);
  localparam logic [PROG_ADDR_W-1:0] FLASH_MASK =
    LARGE_FLASH ? LARGE_FLASH_MASK : SMALL_FLASH_MASK;

  logic                   dpValid_ff;
  logic                   dpWrite_ff;
  logic                   dpInRange_ff;
  logic [7:0]             dpAddr_ff;
  logic [7:0]             dataLow_ff;
  logic [DATA_HIGH_W-1:0] dataHigh_ff;
  logic [7:0]             addrLow_ff;
  logic [ADDR_HIGH_W-1:0] addrHigh_ff;
  logic                   space_ff;
  logic                   permit_ff;
  logic                   abort_ff;
  logic                   doneFlag_ff;
  logic [CNT_W-1:0]       cnt_ff;
  logic [PROG_ADDR_W-1:0] flashAddr_ff;
  logic                   progAccess_ff;
  unlock_e                stage_ff;
  state_e                 state_ff;
  logic [7:0]             ee [EE_DEPTH];

  logic [7:0]             wdat;
  logic                   apTake;
  logic                   sysRst;
  logic                   busy;
  logic                   writing;
  logic                   reading;
  logic                   anyWrite;
  logic                   wrDataLow;
  logic                   wrDataHigh;
  logic                   wrAddrLow;
  logic                   wrAddrHigh;
  logic                   wrCtl;
  logic                   wrUnlock;
  logic                   wrFlags;
  logic                   startWrite;
  logic                   startRead;
  logic                   startEeRead;
  logic                   startPgRead;
  logic                   pgCapture;
  logic                   doneWrite;
  logic [7:0]             eeDataOut;
  logic [7:0]             ctlByte;
  logic [7:0]             rdByte;
  logic [7:0]             nxt_dataLow;
  logic [DATA_HIGH_W-1:0] nxt_dataHigh;
  logic [7:0]             nxt_addrLow;
  logic [ADDR_HIGH_W-1:0] nxt_addrHigh;
  unlock_e                nxt_stage;
  state_e                 nxt_state;

  // true when the write data phase targets the given register
  function automatic logic regWrite(input logic [7:0] ofs, input logic v, input logic w,
                                    input logic r, input logic [7:0] a);
    regWrite = v & w & r & (a == ofs);
  endfunction : regWrite

  // ---------------------------------------------------------------------------
  // ahb-lite slave: zero wait state, always okay
  // ---------------------------------------------------------------------------
  assign apTake    = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wdat      = hwdata[7:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dpValid_ff   <= 1'b0;
      dpWrite_ff   <= 1'b0;
      dpInRange_ff <= 1'b0;
      dpAddr_ff    <= BYTE_ZERO;
    end else if (hready) begin
      dpValid_ff   <= apTake;
      dpWrite_ff   <= hwrite;
      dpInRange_ff <= (haddr[31:8] == 24'h000000);
      dpAddr_ff    <= haddr[7:0];
    end
  end

  assign anyWrite   = dpValid_ff & dpWrite_ff;
  assign wrDataLow  = regWrite(OFS_DATA_LOW, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);
  assign wrDataHigh = regWrite(OFS_DATA_HIGH, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);
  assign wrAddrLow  = regWrite(OFS_ADDR_LOW, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);
  assign wrAddrHigh = regWrite(OFS_ADDR_HIGH, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);
  assign wrCtl      = regWrite(OFS_CONTROL, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);
  assign wrUnlock   = regWrite(OFS_UNLOCK, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);
  assign wrFlags    = regWrite(OFS_FLAGS, dpValid_ff, dpWrite_ff, dpInRange_ff, dpAddr_ff);

  // ---------------------------------------------------------------------------
  // read mux: unlock port and unmapped read zero
  // ---------------------------------------------------------------------------
  assign ctlByte = {space_ff, 3'b000, abort_ff, permit_ff, writing, reading}; // RL18 RL10
  assign rdByte  = !dpInRange_ff               ? BYTE_ZERO :
                   (dpAddr_ff == OFS_DATA_LOW)  ? dataLow_ff :
                   (dpAddr_ff == OFS_ADDR_LOW)  ? addrLow_ff :
                   (dpAddr_ff == OFS_DATA_HIGH) ? {2'b00, dataHigh_ff} : // RL16
                   (dpAddr_ff == OFS_ADDR_HIGH) ? {3'b000, addrHigh_ff} : // RL17
                   (dpAddr_ff == OFS_CONTROL)   ? ctlByte :
                   (dpAddr_ff == OFS_FLAGS)     ? {doneFlag_ff, 7'b0000000} :
                   BYTE_ZERO; // RL15
  assign hrdata  = {24'h000000, rdByte};

  // ---------------------------------------------------------------------------
  // start decode
  // ---------------------------------------------------------------------------
  assign sysRst    = extResetReq | watchdogResetReq | brownoutResetReq;
  assign busy      = (state_ff != ST_IDLE);
  assign writing   = (state_ff == ST_WRITING);
  assign reading   = (state_ff == ST_PG_ADDR) | (state_ff == ST_PG_CAPTURE);
  assign pgCapture = (state_ff == ST_PG_CAPTURE);
  assign doneWrite = writing & (cnt_ff == WRITE_LAST); // RL6 RL24
  assign eeDataOut = ee[addrLow_ff]; // RL1

  // write-start needs the armed unlock, permit and data space
  assign startWrite = wrCtl & wdat[CTL_WRITE] & (stage_ff == UNL_ARMED) & wdat[CTL_PERMIT]
                      & ~wdat[CTL_SPACE] & ~busy & ~sysRst; // RL20 RL21 RL22 RL4 RL25
  assign startRead   = wrCtl & wdat[CTL_READ] & ~startWrite & ~busy & ~sysRst; // RL19 RL25
  assign startEeRead = startRead & ~wdat[CTL_SPACE]; // RL9
  assign startPgRead = startRead & wdat[CTL_SPACE]; // RL9

  // ---------------------------------------------------------------------------
  // unlock sequence tracker
  // ---------------------------------------------------------------------------
  assign nxt_stage = sysRst                                       ? UNL_NONE :
                     (wrUnlock && wdat == KEY_FIRST)              ? UNL_HALF :
                     (wrUnlock && wdat == KEY_SECOND && stage_ff == UNL_HALF) ? UNL_ARMED :
                     anyWrite                                     ? UNL_NONE :
                     stage_ff; // RL20

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (startWrite) begin
          nxt_state = ST_WRITING;
        end else if (startPgRead) begin
          nxt_state = ST_PG_ADDR;
        end
      end
      ST_PG_ADDR:    nxt_state = ST_PG_CAPTURE; // RL23
      ST_PG_CAPTURE: nxt_state = ST_IDLE;
      ST_WRITING: begin
        if (doneWrite) begin
          nxt_state = ST_IDLE; // RL10
        end
      end
      default:       nxt_state = ST_IDLE;
    endcase
    if (sysRst) begin
      nxt_state = ST_IDLE; // RL12
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      stage_ff <= UNL_NONE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      stage_ff <= nxt_stage;
      cnt_ff   <= writing ? cnt_ff + 1'b1 : '0; // RL6
    end
  end

  // ---------------------------------------------------------------------------
  // data and address registers
  // ---------------------------------------------------------------------------
  assign nxt_dataLow  = sysRst               ? BYTE_ZERO : // RL13
                        startEeRead          ? eeDataOut : // RL23
                        pgCapture            ? flashData[7:0] : // RL2
                        (wrDataLow && !busy) ? wdat : dataLow_ff; // RL25
  assign nxt_dataHigh = sysRst                ? '0 :
                        pgCapture             ? flashData[PROG_WORD_W-1:8] : // RL16
                        (wrDataHigh && !busy) ? wdat[DATA_HIGH_W-1:0] : dataHigh_ff;
  assign nxt_addrLow  = sysRst               ? BYTE_ZERO :
                        (wrAddrLow && !busy) ? wdat : addrLow_ff; // RL8
  assign nxt_addrHigh = sysRst                ? '0 :
                        (wrAddrHigh && !busy) ? wdat[ADDR_HIGH_W-1:0] : addrHigh_ff; // RL17

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dataLow_ff  <= BYTE_ZERO;
      dataHigh_ff <= '0;
      addrLow_ff  <= BYTE_ZERO;
      addrHigh_ff <= '0;
    end else begin
      dataLow_ff  <= nxt_dataLow;
      dataHigh_ff <= nxt_dataHigh;
      addrLow_ff  <= nxt_addrLow;
      addrHigh_ff <= nxt_addrHigh;
    end
  end

  // ---------------------------------------------------------------------------
  // control and flag bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      space_ff    <= 1'b0;
      permit_ff   <= 1'b0;
      abort_ff    <= 1'b0;
      doneFlag_ff <= 1'b0;
    end else if (sysRst) begin
      space_ff    <= 1'b0; // RL9
      permit_ff   <= 1'b0; // RL11
      abort_ff    <= abort_ff | writing; // RL12 RL13
      doneFlag_ff <= 1'b0;
    end else begin
      if (wrCtl && !busy) begin
        space_ff <= wdat[CTL_SPACE];
      end
      if (wrCtl) begin
        permit_ff <= wdat[CTL_PERMIT]; // RL21
        abort_ff  <= wdat[CTL_ABORT];
      end
      if (doneWrite) begin
        doneFlag_ff <= 1'b1; // RL14
      end else if (wrFlags) begin
        doneFlag_ff <= wdat[FLG_DONE];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // storage, flash address and programmer gate
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (doneWrite && !sysRst) begin
      ee[addrLow_ff] <= dataLow_ff; // RL5
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flashAddr_ff  <= '0;
      progAccess_ff <= 1'b0;
    end else begin
      if (startPgRead) begin
        flashAddr_ff <= {addrHigh_ff, addrLow_ff} & FLASH_MASK; // RL2 RL3
      end
      progAccess_ff <= ~codeProtect; // RL7
    end
  end

  assign flashAddr        = flashAddr_ff;
  assign programmerAccess = progAccess_ff;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [CNT_W-1:0] writeAge_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      writeAge_ff <= '0;
    end else begin
      writeAge_ff <= startWrite ? '0 : writeAge_ff + 1'b1;
    end
  end

  sequence pgStartSeq;
    startPgRead ##1 (reading && !sysRst) ##1 (pgCapture && !sysRst);
  endsequence
  sequence writeEndSeq;
    doneWrite && !sysRst;
  endsequence

  prog_read_data_a: assert property (pgStartSeq |=> dataLow_ff == $past(flashData[7:0])
    && dataHigh_ff == $past(flashData[PROG_WORD_W-1:8]) && !reading) // RL23
    else $error("program word not captured on second cycle");
  ee_read_data_a: assert property (startEeRead |=> dataLow_ff == $past(eeDataOut)) // RL23
    else $error("data byte not loaded the cycle after read start");
  write_length_a: assert property (doneWrite |-> writeAge_ff == WRITE_LAST) // RL24
    else $error("write cycle length differs from parameter");
  done_flag_a: assert property (writeEndSeq |=> doneFlag_ff && !writing) // RL14
    else $error("completion flag not set at end of write");
  prog_write_drop_a: assert property (wrCtl && wdat[CTL_SPACE] && !busy |=> !writing) // RL22
    else $error("write started with program space selected");
  unlock_order_a: assert property ($rose(writing) |-> $past(stage_ff) == UNL_ARMED
    && $past(wdat[CTL_PERMIT])) // RL20
    else $error("write started without unlock and permit");
  abort_reset_a: assert property (sysRst && writing |=> abort_ff && !writing
    && addrLow_ff == BYTE_ZERO && dataLow_ff == BYTE_ZERO) // RL12
    else $error("aborted write not flagged or registers not cleared");
  unlock_zero_a: assert property (dpValid_ff && !dpWrite_ff && dpAddr_ff == OFS_UNLOCK
    |-> hrdata == 32'h00000000) // RL15
    else $error("unlock port read not zero");
  ee_store_a: assert property (writeEndSeq |=> eeDataOut == $past(dataLow_ff)) // RL5
    else $error("byte not stored at end of write");
  busy_hold_a: assert property (writing && wrAddrLow && !sysRst |=> $stable(addrLow_ff)) // RL25
    else $error("address changed during write");

endmodule : nvm_indirect_access_ctrl

// file: bench/flash_word_model.sv
module flash_word_model (
  // program flash word port
  input  wire logic [12:0] flashAddr,
  output logic      [13:0] flashData
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------------------
  // 8k-word flash, each word a distinct pattern of its own address
  // -------------------------------------------------------------------------
  assign flashData = {flashAddr[0], flashAddr} ^ 14'h2b6d;

endmodule : flash_word_model

// file: bench/nvm_indirect_access_ctrl_bench.sv
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module nvm_indirect_access_ctrl_bench
  import nvm_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        extResetReq, watchdogResetReq, brownoutResetReq;
  logic [12:0] flashAddr;
  logic [13:0] flashData;
  logic        codeProtect, programmerAccess;
  int          n_fail, check_count;

  nvm_indirect_access_ctrl #(.WRITE_CYCLES(16), .LARGE_FLASH(1'b1)) u_nvm_indirect_access_ctrl (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .extResetReq(extResetReq), .watchdogResetReq(watchdogResetReq),
    .brownoutResetReq(brownoutResetReq), .flashAddr(flashAddr), .flashData(flashData),
    .codeProtect(codeProtect), .programmerAccess(programmerAccess));

  flash_word_model u_flash_word_model (.flashAddr(flashAddr), .flashData(flashData));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // -------------------------------------------------------------------------
  // bus master tasks
  // -------------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic step();
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask : step

  task automatic bus_op(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    step();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    step();
    r = hrdata;
  endtask : bus_op

  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus_op(1'b1, a, d, r);
  endtask : bus_write

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus_op(1'b0, a, 8'h00, r);
    `CHK({hresp, r}, {1'b0, 24'h0, e})
  endtask : expect_reg

  task automatic unlock_and_start(input logic [7:0] ctl);
    bus_write(OFS_UNLOCK, KEY_FIRST);
    bus_write(OFS_UNLOCK, KEY_SECOND);
    bus_write(OFS_CONTROL, ctl);
  endtask : unlock_and_start

  task automatic wait_write_done();
    logic [31:0] r;
    for (int i = 0; i < 40; i++) begin
      bus_op(1'b0, OFS_CONTROL, 8'h00, r);
      if (r[CTL_WRITE] === 1'b0) return;
    end
    n_fail++;
    report_and_stop();
  endtask : wait_write_done

  task automatic ee_store(input logic [7:0] a, input logic [7:0] d);
    bus_write(OFS_ADDR_LOW, a);
    bus_write(OFS_DATA_LOW, d);
    bus_write(OFS_CONTROL, 8'h04);
    unlock_and_start(8'h06);
    wait_write_done();
    bus_write(OFS_FLAGS, 8'h00);
  endtask : ee_store

  task automatic ee_load(input logic [7:0] a, input logic [7:0] e);
    bus_write(OFS_ADDR_LOW, a);
    bus_write(OFS_DATA_LOW, 8'h00);
    bus_write(OFS_CONTROL, 8'h01);
    expect_reg(OFS_DATA_LOW, e);
  endtask : ee_load

  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  task automatic reset_values();
    expect_reg(OFS_DATA_LOW, 8'h00);
    expect_reg(OFS_ADDR_LOW, 8'h00);
    expect_reg(OFS_DATA_HIGH, 8'h00);
    expect_reg(OFS_ADDR_HIGH, 8'h00);
    expect_reg(OFS_CONTROL, 8'h00);
    expect_reg(OFS_FLAGS, 8'h00);
    bus_write(OFS_UNLOCK, KEY_FIRST);
    expect_reg(OFS_UNLOCK, 8'h00);
    expect_reg(8'h1c, 8'h00);
  endtask : reset_values

  task automatic ee_write_read();
    bus_write(OFS_ADDR_LOW, 8'hff);
    bus_write(OFS_DATA_LOW, 8'h3c);
    bus_write(OFS_CONTROL, 8'h04);
    unlock_and_start(8'h06);
    expect_reg(OFS_CONTROL, 8'h06);
    bus_write(OFS_CONTROL, 8'h01);
    bus_write(OFS_ADDR_LOW, 8'h11);
    expect_reg(OFS_CONTROL, 8'h02);
    expect_reg(OFS_ADDR_LOW, 8'hff);
    wait_write_done();
    expect_reg(OFS_CONTROL, 8'h00);
    expect_reg(OFS_FLAGS, 8'h80);
    bus_write(OFS_FLAGS, 8'h00);
    expect_reg(OFS_FLAGS, 8'h00);
    ee_load(8'hff, 8'h3c);
    expect_reg(OFS_CONTROL, 8'h00);
    ee_store(8'hff, 8'hc3);
    ee_store(8'h00, 8'h5a);
    ee_load(8'hff, 8'hc3);
    ee_load(8'h00, 8'h5a);
  endtask : ee_write_read

  task automatic bad_sequence();
    ee_store(8'h40, 8'h21);
    bus_write(OFS_DATA_LOW, 8'h99);
    bus_write(OFS_CONTROL, 8'h06);
    expect_reg(OFS_CONTROL, 8'h04);
    bus_write(OFS_CONTROL, 8'h00);
    unlock_and_start(8'h02);
    expect_reg(OFS_CONTROL, 8'h00);
    bus_write(OFS_UNLOCK, KEY_FIRST);
    bus_write(OFS_DATA_LOW, 8'h99);
    bus_write(OFS_UNLOCK, KEY_SECOND);
    bus_write(OFS_CONTROL, 8'h06);
    expect_reg(OFS_CONTROL, 8'h04);
    bus_write(OFS_UNLOCK, KEY_SECOND);
    bus_write(OFS_UNLOCK, KEY_FIRST);
    bus_write(OFS_CONTROL, 8'h06);
    expect_reg(OFS_CONTROL, 8'h04);
    unlock_and_start(8'h86);
    expect_reg(OFS_CONTROL, 8'h84);
    expect_reg(OFS_FLAGS, 8'h00);
    bus_write(OFS_CONTROL, 8'h00);
    ee_load(8'h40, 8'h21);
  endtask : bad_sequence

  task automatic prog_read();
    logic [13:0] w;
    logic [31:0] r;
    w = {1'b0, 13'h1f34} ^ 14'h2b6d;
    bus_write(OFS_ADDR_HIGH, 8'hff);
    expect_reg(OFS_ADDR_HIGH, 8'h1f);
    bus_write(OFS_DATA_HIGH, 8'hff);
    expect_reg(OFS_DATA_HIGH, 8'h3f);
    bus_write(OFS_ADDR_LOW, 8'h34);
    bus_write(OFS_CONTROL, 8'h81);
    bus_op(1'b0, OFS_CONTROL, 8'h00, r);
    `CHK(r, 32'h00000081)
    expect_reg(OFS_CONTROL, 8'h80);
    `CHK(flashAddr, 13'h1f34)
    expect_reg(OFS_DATA_LOW, w[7:0]);
    expect_reg(OFS_DATA_HIGH, {2'b00, w[13:8]});
  endtask : prog_read

  task automatic warm_resets();
    for (int k = 0; k < 3; k++) begin
      bus_write(OFS_ADDR_LOW, 8'h55);
      bus_write(OFS_DATA_LOW, 8'h66);
      bus_write(OFS_CONTROL, 8'h04);
      unlock_and_start(8'h06);
      {extResetReq, watchdogResetReq, brownoutResetReq} <= 3'b100 >> k;
      @(posedge mclk);
      {extResetReq, watchdogResetReq, brownoutResetReq} <= 3'b000;
      expect_reg(OFS_CONTROL, 8'h08);
      expect_reg(OFS_ADDR_LOW, 8'h00);
      expect_reg(OFS_DATA_LOW, 8'h00);
      bus_write(OFS_CONTROL, 8'h00);
    end
  endtask : warm_resets

  task automatic code_protect();
    codeProtect <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(programmerAccess, 1'b0)
    codeProtect <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(programmerAccess, 1'b1)
  endtask : code_protect

  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    {extResetReq, watchdogResetReq, brownoutResetReq} = 3'b000;
    codeProtect = 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    reset_values();
    ee_write_read();
    bad_sequence();
    prog_read();
    warm_resets();
    code_protect();
    report_and_stop();
  end

endmodule : nvm_indirect_access_ctrl_bench
